// File: hw/iorcr_cfg.svh
// Constants for the I/O read collision resolver
`ifndef IORCR_CFG_SVH
`define IORCR_CFG_SVH
`define IORCR_ADDR_W      32
`define IORCR_GRAN_LSB    5
`define IORCR_SLOTS       4
`define IORCR_SRC_W       8
`define IORCR_SLOTS_MAX   16
`define IORCR_GRAN_LSB_MAX 12
`endif

// File: hw/iorcr_pkg.sv
// Types shared by the I/O read collision resolver
package iorcr_pkg;
   typedef enum logic [3:0] {
      IORCR_OP_READ_HOME,
      IORCR_OP_IREAD_HOME,
      IORCR_OP_READ_OWNER,
      IORCR_OP_RFO_HOME,
      IORCR_OP_RFO_OWNER,
      IORCR_OP_DKILL_HOME,
      IORCR_OP_DKILL_SHARER,
      IORCR_OP_CASTOUT,
      IORCR_OP_TLB_INVAL,
      IORCR_OP_TLB_SYNC,
      IORCR_OP_IKILL_HOME,
      IORCR_OP_IKILL_SHARER,
      IORCR_OP_FLUSH,
      IORCR_OP_IORD_HOME,
      IORCR_OP_IORD_OWNER
   } iorcr_op_t;

   typedef enum logic [2:0] {
      IORCR_RSP_DONE,
      IORCR_RSP_RETRY,
      IORCR_RSP_ERROR,
      IORCR_RSP_NOT_OWNER
   } iorcr_rsp_t;

   // Incoming request from the fabric
   typedef struct packed {
      iorcr_op_t        op;
      logic [31:0]      addr;
      logic [7:0]       src;
   } iorcr_req_t;

   // Response returned to the requester
   typedef struct packed {
      iorcr_rsp_t       rsp;
      logic [7:0]       dst;
   } iorcr_ans_t;

   // Operation forwarded to the local processor or to the directory
   typedef struct packed {
      iorcr_op_t        op;
      logic [31:0]      addr;
      logic [7:0]       src;
      logic             ikill_bcast;
      logic             ret_data;
   } iorcr_fwd_t;
endpackage

// File: hw/iorcr_resolver.sv
// Collision resolver for outstanding local I/O reads
`timescale 1ns/1ns
`include "iorcr_cfg.svh"

module iorcr_resolver
   import iorcr_pkg::*;
#(
   parameter int SLOTS  = `IORCR_SLOTS,
   parameter int GRAN_LSB = `IORCR_GRAN_LSB
) (
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire logic              participant_i,
   // Local outstanding I/O read slots
   input  wire logic [SLOTS-1:0]  slot_issue_i,
   input  wire logic              slot_owner_i,
   input  wire logic [31:0]       slot_addr_i,
   input  wire logic [SLOTS-1:0]  slot_final_i,
   input  wire logic              slot_final_retry_i,
   input  wire logic              slot_has_data_i,
   output logic [SLOTS-1:0]       slot_busy_o,
   // Incoming request
   input  wire logic              req_valid_i,
   input  iorcr_req_t             req_i,
   output logic                   req_ready_o,
   // Response to the requester
   output logic                   ans_valid_o,
   output iorcr_ans_t             ans_o,
   input  wire logic              ans_ready_i,
   // Forward to processor or directory
   output logic                   fwd_valid_o,
   output iorcr_fwd_t             fwd_o,
   input  wire logic              fwd_ready_i
);

   ////////////////////////////////////////////////////////////////////////////
   // Elaboration checks
   // The slot table is a flat hit vector, one bit per slot; beyond the upper bound the
   // or-reduction tree and the per-slot compare grow past what one cycle holds.
   initial begin
      if (SLOTS < 1 || SLOTS > `IORCR_SLOTS_MAX) begin
         $error("iorcr_resolver: slot count out of range");
      end
   end

   // A granule finer than a byte or coarser than a page makes no sense here
   initial begin
      if (GRAN_LSB < 0 || GRAN_LSB > `IORCR_GRAN_LSB_MAX) begin
         $error("iorcr_resolver: granule size out of range");
      end
   end

   typedef enum logic [2:0] {
      S_IDLE,
      S_WAIT,
      S_FWD,
      S_ANS
   } iorcr_state_t;

   iorcr_state_t             state_reg;
   logic [SLOTS-1:0]         busy_reg;
   logic [SLOTS-1:0]         owner_reg;
   logic [SLOTS-1:0]         retry_reg;
   logic [SLOTS-1:0]         data_reg;
   logic [31:0]              addr_reg [SLOTS];
   iorcr_req_t               req_reg;
   logic [SLOTS-1:0]         hit_reg;
   iorcr_rsp_t               rsp_reg;
   logic                     bcast_reg;
   logic                     retdata_reg;

   // Same coherence granule test
   function automatic logic same_gran(input logic [31:0] a, input logic [31:0] b);
      same_gran = ((a ^ b) >> GRAN_LSB) == 32'h0000_0000;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Outstanding slot table
   // Each slot remembers one local I/O read from issue until its final response.
   // Issue and final in the same cycle: issue wins, so a reused slot is never
   // freed by the tail of its previous transaction.
   // The final response kind and data flag are kept after the slot frees, so a
   // held sharer data kill can still see how its colliding read ended.
   logic [SLOTS-1:0] hit;
   genvar g;
   generate
      for (g = 0; g < SLOTS; g++) begin : g_slot
         assign hit[g] = busy_reg[g] && same_gran(addr_reg[g], req_i.addr);
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               busy_reg[g]  <= 1'b0;
               owner_reg[g] <= 1'b0;
               retry_reg[g] <= 1'b0;
               data_reg[g]  <= 1'b0;
               addr_reg[g]  <= 32'h0000_0000;
            end else if (slot_issue_i[g]) begin
               busy_reg[g]  <= 1'b1;
               owner_reg[g] <= slot_owner_i;
               addr_reg[g]  <= slot_addr_i;
            end else if (slot_final_i[g] && busy_reg[g]) begin
               busy_reg[g]  <= 1'b0;
               retry_reg[g] <= slot_final_retry_i;
               data_reg[g]  <= slot_has_data_i;
            end
         end
      end
   endgenerate
   assign slot_busy_o = busy_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Resolution decode
   // Priority order of the decode:
   //   1. TLB maintenance never collides and is always forwarded.
   //   2. No granule match: forward the request and answer done.
   //   3. Non-participant: only the sharer instruction kill is served.
   //   4. A match on an owner-directed slot takes the owner table.
   //   5. Otherwise the home-directed table applies.
   // A request that matches both kinds of slot takes the owner table, since
   // that read is the one that can still change the directory.
   logic       any_hit;
   logic       any_owner;
   iorcr_rsp_t dec_rsp;
   logic       dec_fwd;
   logic       dec_wait;
   logic       dec_bcast;
   assign any_hit   = |hit;
   assign any_owner = |(hit & owner_reg);

   always_comb begin
      dec_rsp   = IORCR_RSP_DONE;
      dec_fwd   = 1'b1;
      dec_wait  = 1'b0;
      dec_bcast = 1'b0;
      if (req_i.op == IORCR_OP_TLB_INVAL || req_i.op == IORCR_OP_TLB_SYNC) begin
         dec_rsp = IORCR_RSP_DONE;
      end else if (!any_hit) begin
         // Nothing outstanding on the granule: a sharer kill goes straight out
         dec_wait  = 1'b0;
         dec_bcast = (req_i.op == IORCR_OP_IKILL_HOME);
      end else if (!participant_i) begin
         // A pure I/O element has no directory bit: coherent traffic other than the sharer instruction kill is a fault
         if (req_i.op == IORCR_OP_IKILL_SHARER) begin
            dec_rsp = IORCR_RSP_DONE;
         end else begin
            dec_rsp = IORCR_RSP_ERROR;
            dec_fwd = 1'b0;
         end
      end else if (any_owner) begin
         // Owner-directed read in flight: home traffic other than the home instruction
         // kill is retried, owner traffic is a fault, castout slips past the collision check
         case (req_i.op)
            IORCR_OP_CASTOUT: dec_rsp = IORCR_RSP_DONE;
            IORCR_OP_IKILL_HOME: begin
               dec_rsp   = IORCR_RSP_DONE;
               dec_bcast = 1'b1;
            end
            IORCR_OP_READ_OWNER, IORCR_OP_RFO_OWNER, IORCR_OP_DKILL_SHARER,
            IORCR_OP_IKILL_SHARER, IORCR_OP_IORD_OWNER: begin
               dec_rsp = IORCR_RSP_ERROR;
               dec_fwd = 1'b0;
            end
            default: begin
               dec_rsp = IORCR_RSP_RETRY;
               dec_fwd = 1'b0;
            end
         endcase
      end else begin
         // Home-directed read in flight: we do not own the granule
         case (req_i.op)
            IORCR_OP_READ_OWNER, IORCR_OP_RFO_OWNER, IORCR_OP_IORD_OWNER: begin
               dec_rsp = IORCR_RSP_NOT_OWNER;
               dec_fwd = 1'b0;
            end
            IORCR_OP_DKILL_SHARER: dec_wait = 1'b1;
            IORCR_OP_IKILL_SHARER: dec_rsp = IORCR_RSP_DONE;
            default: begin
               dec_rsp = IORCR_RSP_ERROR;
               dec_fwd = 1'b0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Request sequencing
   // One request at a time: it is taken in idle, may wait for colliding reads
   // to finish, may be forwarded, and is then answered. Ready is low for the
   // whole span, so a second request is never decoded against stale slots.
   assign req_ready_o = (state_reg == S_IDLE);
   assign ans_valid_o = (state_reg == S_ANS);
   assign fwd_valid_o = (state_reg == S_FWD);

   // Slots still awaiting their final response for the held kill
   logic [SLOTS-1:0] pend;
   assign pend = hit_reg & busy_reg;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg   <= S_IDLE;
         req_reg     <= '0;
         hit_reg     <= '0;
         rsp_reg     <= IORCR_RSP_DONE;
         bcast_reg   <= 1'b0;
         retdata_reg <= 1'b0;
      end else begin
         case (state_reg)
            // Take the request and freeze its decision
            S_IDLE: begin
               if (req_valid_i) begin
                  req_reg     <= req_i;
                  hit_reg     <= hit;
                  rsp_reg     <= dec_rsp;
                  bcast_reg   <= dec_bcast;
                  retdata_reg <= 1'b0;
                  if (dec_wait) begin
                     state_reg <= S_WAIT;
                  end else if (dec_fwd) begin
                     state_reg <= S_FWD;
                  end else begin
                     state_reg <= S_ANS;
                  end
               end
            end
            // Hold the sharer kill until every colliding read has ended
            S_WAIT: begin
               if (pend == '0) begin
                  // Done with data returns it; retry or none just forwards
                  retdata_reg <= |(hit_reg & ~retry_reg & data_reg);
                  state_reg   <= S_FWD;
               end
            end
            // Processor or directory takes the forwarded operation
            S_FWD: begin
               if (fwd_ready_i) begin
                  state_reg <= S_ANS;
               end
            end
            // Requester takes the response
            S_ANS: begin
               if (ans_ready_i) begin
                  state_reg <= S_IDLE;
               end
            end
            default: state_reg <= S_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Output carriers from flip-flops
   // Both carriers are pure wiring of held registers, so they stay stable
   // for as long as their valid waits on a stalled far side.
   always_comb begin
      ans_o.rsp        = rsp_reg;
      ans_o.dst        = req_reg.src;
      fwd_o.op         = req_reg.op;
      fwd_o.addr       = req_reg.addr;
      fwd_o.src        = req_reg.src;
      fwd_o.ikill_bcast = bcast_reg;
      fwd_o.ret_data   = retdata_reg;
   end

endmodule

// File: verif/iorcr_far_model.sv
// Far-side model: requester and processor that stall at random
`timescale 1ns/1ns
module iorcr_far_model (
   input  wire logic [1:0] stall_i,
   output logic            ans_ready_o,
   output logic            fwd_ready_o
);
   // Requester takes answers whenever stall_i[0] is low
   assign ans_ready_o = !stall_i[0];
   // Processor and directory take forwarded operations
   assign fwd_ready_o = !stall_i[1];
endmodule

// File: verif/iorcr_resolver_assertions.sv
// Port assertions for the I/O read collision resolver
`timescale 1ns/1ns
module iorcr_resolver_chk
   import iorcr_pkg::*;
#(
   parameter int SLOTS = 4
) (
   input wire logic             clk_i,
   input wire logic             rst_i,
   input wire logic             participant_i,
   input wire logic [SLOTS-1:0] slot_busy_o,
   input wire logic             req_valid_i,
   input wire logic             req_ready_o,
   input wire logic             ans_valid_o,
   input wire iorcr_ans_t       ans_o,
   input wire logic             ans_ready_i,
   input wire logic             fwd_valid_o,
   input wire iorcr_fwd_t       fwd_o,
   input wire logic             fwd_ready_i
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   ////////////////////////////////////////////////////////////////////////////////
   // Handshake, ordering and response cause checks
   chk_ans_hold: assert property (ans_valid_o && !ans_ready_i |=> ans_valid_o && $stable(ans_o))
      else $error("answer dropped");
   chk_fwd_hold: assert property (fwd_valid_o && !fwd_ready_i |=> fwd_valid_o && $stable(fwd_o))
      else $error("forward dropped");
   chk_busy_refuse: assert property (ans_valid_o || fwd_valid_o |-> !req_ready_o)
      else $error("ready while busy");
   chk_tlb_done: assert property (fwd_valid_o && fwd_ready_i && fwd_o.op inside {IORCR_OP_TLB_INVAL,
      IORCR_OP_TLB_SYNC} |=> ans_valid_o && ans_o.rsp == IORCR_RSP_DONE) else $error("tlb not done");
   chk_retry_cause: assert property ($rose(ans_valid_o) && ans_o.rsp == IORCR_RSP_RETRY
      |-> $past(|slot_busy_o) && participant_i) else $error("retry without slot");
   chk_notown_part: assert property (ans_valid_o && ans_o.rsp == IORCR_RSP_NOT_OWNER |-> participant_i)
      else $error("not-owner from non-participant");
   chk_reset_idle: assert property ($fell(rst_i) |-> !ans_valid_o && !fwd_valid_o && req_ready_o
      && slot_busy_o == '0) else $error("not idle after reset");
   chk_free_fwd: assert property (req_valid_i && req_ready_o && slot_busy_o == '0
      |=> fwd_valid_o && !ans_valid_o) else $error("free request not forwarded");
   chk_done_fwd: assert property ($rose(ans_valid_o) && ans_o.rsp == IORCR_RSP_DONE
      |-> $past(fwd_valid_o && fwd_ready_i)) else $error("done before forward");
endmodule
bind iorcr_resolver iorcr_resolver_chk #(.SLOTS(SLOTS)) iorcr_resolver_chk_i (.clk_i, .rst_i, .participant_i,
   .slot_busy_o, .req_valid_i, .req_ready_o, .ans_valid_o, .ans_o, .ans_ready_i, .fwd_valid_o, .fwd_o, .fwd_ready_i);

// File: verif/iorcr_resolver_tb_top.sv
// Self-checking bench for the I/O read collision resolver
`timescale 1ns/1ns
module iorcr_resolver_tb_top
   import iorcr_pkg::*;
;
   logic        clk_i = 0;
   logic        rst_i = 1;
   logic        participant_i = 1;
   logic        slot_owner_i = 0;
   logic        slot_final_retry_i = 0;
   logic        slot_has_data_i = 0;
   logic        req_valid_i = 0;
   logic [3:0]  slot_issue_i = '0;
   logic [3:0]  slot_final_i = '0;
   logic [31:0] slot_addr_i = '0;
   iorcr_req_t  req_i = '0;
   logic [1:0]  stall = '0;
   logic [31:0] seed = 32'h0000_44d4;
   logic [31:0] sseed = 32'h0000_44d4;
   logic [4:0]  exp_q[$];
   logic        seen_fwd = 0;
   logic        seen_ret = 0;
   int          num_errors = 0;
   int          n_compared = 0;
   logic [3:0]  slot_busy_o;
   logic        req_ready_o, ans_valid_o, ans_ready_i, fwd_valid_o, fwd_ready_i;
   iorcr_ans_t  ans_o;
   iorcr_fwd_t  fwd_o;

   iorcr_resolver iorcr_resolver_i (.clk_i, .rst_i, .participant_i, .slot_issue_i, .slot_owner_i, .slot_addr_i,
      .slot_final_i, .slot_final_retry_i, .slot_has_data_i, .slot_busy_o, .req_valid_i, .req_i, .req_ready_o,
      .ans_valid_o, .ans_o, .ans_ready_i, .fwd_valid_o, .fwd_o, .fwd_ready_i);
   iorcr_far_model iorcr_far_model_i (.stall_i(stall), .ans_ready_o(ans_ready_i), .fwd_ready_o(fwd_ready_i));

   ////////////////////////////////////////////////////////////////////////////////
   // Xorshift step
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction

   initial forever #20 clk_i = ~clk_i;

   // Far-side stalls from their own generator
   always @(posedge clk_i) begin
      sseed <= xs(sseed);
      stall <= sseed[9:8] & sseed[3:2];
   end

   // Watch forwards and answers, compare with the oldest note
   always @(posedge clk_i) begin
      if (fwd_valid_o === 1'b1 && fwd_ready_i) begin
         seen_fwd = 1;
         seen_ret = fwd_o.ret_data;
      end
      if (ans_valid_o === 1'b1 && ans_ready_i) begin
         n_compared++;
         if (exp_q.size() == 0 || exp_q[0] !== {seen_fwd, seen_ret, ans_o.rsp}) begin
            $display("BAD answer exp %h got %h", exp_q[0], {seen_fwd, seen_ret, ans_o.rsp});
            num_errors++;
         end
         if (exp_q.size() > 0) void'(exp_q.pop_front());
         seen_fwd = 0;
         seen_ret = 0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // One request against an optional slot; c gives the expected resolution
   task automatic do_op(input logic own, input logic hit, input int k, input byte c);
      logic [31:0] r;
      logic        wt;
      int          n;
      seed = xs(seed);
      r = seed;
      wt = hit && participant_i && !own && k == 6;
      if (hit) begin
         slot_issue_i <= 4'h1;
         slot_owner_i <= own;
         slot_addr_i <= 32'h0000_4000;
         @(posedge clk_i);
         slot_issue_i <= '0;
      end
      req_i <= '{iorcr_op_t'(k), 32'h0000_4000 | 32'(r[4:0]), r[15:8]};
      req_valid_i <= 1;
      exp_q.push_back(wt ? {1'b1, !r[16] && r[17], IORCR_RSP_DONE} :
         c == "d" ? {2'b10, IORCR_RSP_DONE} : c == "R" ? {2'b00, IORCR_RSP_RETRY} :
         c == "n" ? {2'b00, IORCR_RSP_NOT_OWNER} : {2'b00, IORCR_RSP_ERROR});
      do @(posedge clk_i); while (req_ready_o !== 1'b1);
      req_valid_i <= 0;
      if (hit) begin
         n_compared++;
         if (slot_busy_o[0] !== 1'b1) begin
            $display("BAD slot_busy exp 1 got %b", slot_busy_o[0]);
            num_errors++;
         end
      end
      if (wt) begin
         repeat (3) @(posedge clk_i);
         slot_final_i <= 4'h1;
         slot_final_retry_i <= r[16];
         slot_has_data_i <= r[17];
         @(posedge clk_i);
         slot_final_i <= '0;
      end
      n = 0;
      while (exp_q.size() > 0 && n < 60) begin
         @(posedge clk_i);
         n++;
      end
      if (n == 60) num_errors++;
      if (slot_busy_o[0] === 1'b1) begin
         slot_final_i <= 4'h1;
         @(posedge clk_i);
         slot_final_i <= '0;
      end
      @(posedge clk_i);
   endtask

   // Every request type against one kind of outstanding read, or against no slot when hit is low
   task automatic run_pass(input logic part, input logic own, input logic hit, input string t);
      participant_i <= part;
      @(posedge clk_i);
      for (int k = 0; k < 15; k++) do_op(own, hit, k, t[k]);
   endtask

   task automatic give_verdict();
      $display("errors %0d compared %0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 0;
      run_pass(1, 0, 1, "EEnEnEdEddEdEEn");
      run_pass(0, 0, 1, "EEEEEEEEddEdEEE");
      run_pass(1, 1, 1, "RREREREddddERRE");
      run_pass(1, 0, 0, "ddddddddddddddd");
      give_verdict();
   end

   // Watchdog
   initial begin
      #(40 * 5000);
      num_errors++;
      give_verdict();
   end
endmodule
